// ==== src/lock_pkg.sv ====
// shared constants for the two-wire slave with bank lock word
// assumes a single 100 MHz clock domain on both ends
package lock_pkg;
  // ****************************************
  // select code
  // ****************************************
  localparam logic [3:0]  TYPE_ID          = 4'h5; // arbitrary value
  localparam logic [2:0]  DEV_ADDR_RESET   = 3'h1;
  localparam int          DIR_BIT          = 0;
  // ****************************************
  // memory address layout
  // ****************************************
  localparam int          ADDR_SPACE_BIT   = 15;
  localparam int          ADDR_BANK_HI     = 14;
  localparam int          ADDR_BANK_LO     = 13;
  localparam int          ADDR_BYTE_BIT    = 0;
  localparam logic [15:0] LOCK_WORD_ADDR   = 16'h803c;
  localparam logic [1:0]  BANK_EPC         = 2'h1;
  localparam logic [1:0]  BANK_USER        = 2'h3;
  // ****************************************
  // lock word fields (serial layout, 32 bits)
  // ****************************************
  localparam int          MASK_POS         = 16;
  localparam int          ACT_POS          = 0;
  localparam int          FIELD_OFS        = 6;
  localparam logic [31:0] LOCK_RESET       = 32'h0000_0000;
  // ****************************************
  // timing and master register addresses
  // ****************************************
  localparam int          CLK_NS           = 10;
  localparam int          WRITE_CYCLE_NS   = 5000;
  localparam int          WRITE_CYCLES     = (WRITE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SCL_HALF_CYCLES  = 8;
  localparam logic [1:0]  REG_CMD          = 2'h0;
  localparam logic [1:0]  REG_STATUS       = 2'h1;
  localparam logic [1:0]  REG_RDATA        = 2'h2;
endpackage

// ==== src/twi_if.sv ====
// two-wire bus between master end and device end
// open-drain lines resolved from the output enables (low enable drives low)
`timescale 1ns/1ps
interface twi_if;
  logic scl_oe_n;
  logic sda_m_oe_n;
  logic sda_s_oe_n;
  wire  scl = scl_oe_n;
  wire  sda = sda_m_oe_n & sda_s_oe_n;
  modport master (output scl_oe_n, output sda_m_oe_n, input scl, input sda);
  modport device (output sda_s_oe_n, input scl, input sda);
endinterface

// ==== src/lock_slave.sv ====
// device end: two-wire slave with select decode and bank lock word
// assumes scl/sda are asynchronous pins; memory itself lives outside
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module lock_slave
  import lock_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  twi_if.device            bus,
  input  wire logic [2:0]  i_cfg_dev_addr,
  input  wire logic        i_cfg_dev_load,
  input  wire logic [19:0] i_rf_lock_payload,
  input  wire logic        i_rf_lock_valid,
  input  wire logic [7:0]  i_mem_rdata,
  output logic      [15:0] o_mem_addr,
  output logic      [7:0]  o_mem_wdata,
  output logic             o_mem_we,
  output logic             o_prog_busy,
  output logic      [9:0]  o_lock_state
);
  import lock_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RX   = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_TX   = 6'b001000,
    ST_TACK = 6'b010000,
    ST_PROG = 6'b100000
  } state_e;

  // ****************************************
  // pin synchronisers and conditions
  // ****************************************
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_q, sda_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end
  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  // ****************************************
  // transfer state
  // ****************************************
  state_e      state_q;
  logic [7:0]  shift_q;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q;     // 0 select, 1 addr hi, 2 addr lo, 3 data
  logic        sel_q, rd_q, wr_pend_q, ack_q, drive_q, nack_q;
  logic [15:0] addr_q;
  logic [2:0]  dev_q;
  logic [31:0] lock_q;
  logic [15:0] prog_cnt_q;

  wire       sel_hit   = (shift_q[7:4] == TYPE_ID) && (shift_q[3:1] == dev_q);
  wire       is_lock   = (addr_q & 16'hfffc) == LOCK_WORD_ADDR;
  wire [1:0] lock_byte = addr_q[1:0];
  wire [1:0] bank      = addr_q[ADDR_BANK_HI:ADDR_BANK_LO];
  wire       space_sel = addr_q[ADDR_SPACE_BIT];

  function automatic logic [7:0] lock_rd(input logic [31:0] w, input logic [1:0] b);
    lock_rd = w[8'(31 - 8 * b) -: 8];
  endfunction

  // passwords read as zero in both mask and action fields
  wire [31:0] lock_vis = lock_q & 32'h0fc0_0fc0;
  wire [7:0]  tx_byte  = is_lock ? lock_rd(lock_vis, lock_byte) : i_mem_rdata;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) dev_q <= DEV_ADDR_RESET;
    else if (i_cfg_dev_load) dev_q <= i_cfg_dev_addr;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00; bit_q <= 4'h0; byte_q <= 2'h0;
      sel_q <= 1'b0; rd_q <= 1'b0; wr_pend_q <= 1'b0; ack_q <= 1'b0;
      drive_q <= 1'b0; nack_q <= 1'b0; addr_q <= 16'h0000;
      lock_q <= LOCK_RESET; prog_cnt_q <= 16'h0000;
      o_mem_we <= 1'b0; o_mem_wdata <= 8'h00;
    end else begin
      o_mem_we <= 1'b0;
      if (i_rf_lock_valid) begin
        // each of five areas has two mask and two action bits
        for (int k = 0; k < 10; k++) begin
          if (i_rf_lock_payload[10 + k])
            lock_q[FIELD_OFS + k] <= i_rf_lock_payload[k];
        end
      end
      if (state_q == ST_PROG) begin
        drive_q <= 1'b0;
        if (prog_cnt_q == 16'(WRITE_CYCLES - 1)) state_q <= ST_IDLE;
        prog_cnt_q <= prog_cnt_q + 16'h0001;
      end else if (stop_c) begin
        drive_q <= 1'b0;
        // the stop's own scl rise is counted as one bit of the next byte
        if (wr_pend_q && state_q == ST_RX && bit_q <= 4'h1) begin
          state_q <= ST_PROG; prog_cnt_q <= 16'h0000;
        end else state_q <= ST_IDLE;
        wr_pend_q <= 1'b0;
      end else if (start_c) begin
        state_q <= ST_RX; bit_q <= 4'h0; byte_q <= 2'h0;
        sel_q <= 1'b0; drive_q <= 1'b0; wr_pend_q <= 1'b0;
      end else begin
        case (state_q)
          ST_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_q   <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              ack_q <= 1'b1;
              if (byte_q == 2'h0) begin
                if (sel_hit) begin
                  sel_q <= 1'b1; rd_q <= shift_q[DIR_BIT]; drive_q <= 1'b1;
                  state_q <= ST_ACK;
                end else state_q <= ST_IDLE;
              end else begin
                drive_q <= 1'b1;
                state_q <= ST_ACK;
                if (byte_q == 2'h1) addr_q[15:8] <= shift_q;
                else if (byte_q == 2'h2) addr_q[7:0] <= shift_q;
                else begin
                  wr_pend_q <= 1'b1;
                  o_mem_wdata <= shift_q;
                  if (is_lock) begin
                    // only epc, tid and user pairs are writable over the wire
                    lock_q[8'(31 - 8 * lock_byte) -: 8] <= shift_q & lock_rd(32'h0fc0_0fc0, lock_byte);
                  end else o_mem_we <= 1'b1;
                  addr_q <= addr_q + 16'h0001;
                end
              end
            end
          end
          ST_ACK: if (scl_fall) begin
            drive_q <= 1'b0;
            if (rd_q && byte_q == 2'h0) begin
              state_q <= ST_TX; shift_q <= tx_byte; bit_q <= 4'h0;
              drive_q <= ~tx_byte[7];
            end else begin
              state_q <= ST_RX;
              if (byte_q != 2'h3) byte_q <= byte_q + 2'h1;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_q   <= bit_q + 4'h1;
              shift_q <= {shift_q[6:0], 1'b1};
              drive_q <= (bit_q == 4'h7) ? 1'b0 : ~shift_q[6];
              if (bit_q == 4'h7) begin
                state_q <= ST_TACK; addr_q <= addr_q + 16'h0001;
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) nack_q <= sda_s;
            if (scl_fall && bit_q == 4'h8) state_q <= ST_IDLE; // parked
            if (scl_rise && !sda_s) bit_q <= 4'h9;
            if (scl_rise && sda_s) state_q <= ST_IDLE;
            if (scl_fall && bit_q == 4'h9) begin
              state_q <= ST_TX; shift_q <= tx_byte; bit_q <= 4'h0;
              drive_q <= ~tx_byte[7];
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // only the data line is ever driven
  assign bus.sda_s_oe_n = ~drive_q;
  assign o_mem_addr     = {space_sel, addr_q[14:0]};
  assign o_prog_busy    = (state_q == ST_PROG);
  assign o_lock_state   = lock_q[FIELD_OFS +: 10];
endmodule

// ==== src/twi_master.sv ====
// master end: drives scl from a divider, runs byte transfers on command
// assumes the device answers within the bus protocol timing
`timescale 1ns/1ps
module twi_master
  import lock_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  twi_if.master           bus,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata
);
  import lock_pkg::*;

  typedef enum logic [4:0] {
    M_IDLE  = 5'b00001,
    M_START = 5'b00010,
    M_BITS  = 5'b00100,
    M_STOP  = 5'b01000,
    M_DONE  = 5'b10000
  } mstate_e;

  // ****************************************
  // command register: [7:0] data; status register writes take bits {start, stop, read, nack}
  // ****************************************
  mstate_e    st_q;
  logic [7:0] tx_q, rx_q;
  logic [3:0] cmd_q;
  logic [3:0] bit_q;
  logic [4:0] div_q;
  logic [1:0] ph_q;
  logic       scl_q, sda_q, acked_q;
  logic [1:0] sda_sync_q;
  wire        tick = (div_q == 5'(SCL_HALF_CYCLES - 1));
  wire        busy = (st_q != M_IDLE);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) sda_sync_q <= 2'b11;
    else sda_sync_q <= {sda_sync_q[0], bus.sda};
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_rdata <= 8'h00;
    else if (i_rd) begin
      case (i_addr)
        REG_STATUS: o_rdata <= {6'h00, acked_q, busy};
        REG_RDATA:  o_rdata <= rx_q;
        default:    o_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= M_IDLE; tx_q <= 8'h00; rx_q <= 8'h00; cmd_q <= 4'h0;
      bit_q <= 4'h0; div_q <= 5'h00; ph_q <= 2'h0;
      scl_q <= 1'b1; sda_q <= 1'b1; acked_q <= 1'b0;
    end else begin
      div_q <= tick ? 5'h00 : div_q + 5'h01;
      if (i_wr && i_addr == REG_CMD && !busy) tx_q <= i_wdata;
      if (i_wr && i_addr == REG_STATUS && !busy) begin
        cmd_q <= i_wdata[3:0];
        bit_q <= 4'h0; ph_q <= 2'h0;
        st_q  <= i_wdata[3] ? M_START : M_BITS;
      end else if (tick) begin
        case (st_q)
          M_START: begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin sda_q <= 1'b1; scl_q <= 1'b1; end
            else if (ph_q == 2'h1) sda_q <= 1'b0;
            else begin scl_q <= 1'b0; st_q <= M_BITS; ph_q <= 2'h0; end
          end
          M_BITS: begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              // data changes in the middle of the scl low phase
              if (bit_q < 4'h8) sda_q <= cmd_q[1] ? 1'b1 : tx_q[3'(7 - bit_q)];
              else sda_q <= cmd_q[1] ? cmd_q[0] : 1'b1;
            end else if (ph_q == 2'h1) begin
              scl_q <= 1'b1;
            end else begin
              if (bit_q < 4'h8) rx_q <= {rx_q[6:0], sda_sync_q[1]};
              else acked_q <= ~sda_sync_q[1];
              scl_q <= 1'b0;
              ph_q  <= 2'h0;
              if (bit_q == 4'h8) st_q <= cmd_q[2] ? M_STOP : M_DONE;
              bit_q <= bit_q + 4'h1;
            end
          end
          M_STOP: begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) sda_q <= 1'b0;
            else if (ph_q == 2'h1) scl_q <= 1'b1;
            else begin sda_q <= 1'b1; st_q <= M_DONE; end
          end
          M_DONE: st_q <= M_IDLE;
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end

  assign bus.scl_oe_n   = scl_q;
  assign bus.sda_m_oe_n = sda_q;
endmodule

// ==== test/twi_monitor.sv ====
// checker for the two-wire link between the master end and the device end
// assumes i_clk samples the resolved wires and sees the device busy level
`timescale 1ns/1ps
module twi_monitor
  import lock_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic scl_oe_n,
  input  wire logic sda_m_oe_n,
  input  wire logic sda_s_oe_n,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic o_prog_busy
);
  // ****************************************
  // helper logic
  // ****************************************
  logic       scl_q;
  logic       sda_q;
  logic       seen_q;
  logic [3:0] stop_age_q;
  logic [9:0] busy_cnt_q;
  logic [7:0] drv_cnt_q;
  wire        start_w = scl & scl_q & sda_q & ~sda;
  wire        stop_w  = scl & scl_q & ~sda_q & sda;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      seen_q     <= 1'b0;
      stop_age_q <= 4'hf;
      busy_cnt_q <= 10'h000;
      drv_cnt_q  <= 8'h00;
    end else begin
      scl_q      <= scl;
      sda_q      <= sda;
      seen_q     <= seen_q | start_w;
      stop_age_q <= stop_w ? 4'h0 : stop_age_q + {3'h0, stop_age_q != 4'hf};
      busy_cnt_q <= o_prog_busy ? busy_cnt_q + 10'h001 : 10'h000;
      drv_cnt_q  <= sda_s_oe_n ? 8'h00 : drv_cnt_q + {7'h00, drv_cnt_q != 8'hff};
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_stop_seen; stop_age_q < 4'h8; endsequence
  sequence s_high8; scl[*8]; endsequence
  sequence s_low8; !scl[*8]; endsequence
  property p_busy_quiet; o_prog_busy |-> sda_s_oe_n; endproperty
  property p_no_start; !seen_q |-> sda_s_oe_n; endproperty
  property p_busy_after_stop; $rose(o_prog_busy) |-> s_stop_seen; endproperty
  property p_busy_len;
    $fell(o_prog_busy) |-> busy_cnt_q inside {[WRITE_CYCLES - 1:WRITE_CYCLES + 1]};
  endproperty
  property p_slave_edge; $changed(sda_s_oe_n) |-> !scl; endproperty
  property p_drive_bound; !sda_s_oe_n |-> drv_cnt_q < 8'd240; endproperty
  property p_scl_high; $rose(scl) |-> s_high8; endproperty
  property p_scl_low; $fell(scl) |-> s_low8; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("device drives sda while busy");
  a_no_start: assert property (p_no_start)
    else $error("device drives sda before any start");
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("write cycle began without a stop");
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
  a_slave_edge: assert property (p_slave_edge)
    else $error("device changed sda while scl high");
  a_drive_bound: assert property (p_drive_bound)
    else $error("device held sda too long");
  a_scl_high: assert property (p_scl_high)
    else $error("scl high phase short");
  a_scl_low: assert property (p_scl_low)
    else $error("scl low phase short");
endmodule

// ==== test/lock_slave_tb.sv ====
// testbench: master end and device end joined by the two-wire interface
// assumes the master register map of the hand-over and a 100 MHz clock
`timescale 1ns/1ps
module lock_slave_tb;
  import lock_pkg::*;
  logic        i_clk             = 1'b0;
  logic        i_arst_n          = 1'b0;
  logic [1:0]  i_addr            = 2'h0;
  logic [7:0]  i_wdata           = 8'h00;
  logic        i_wr              = 1'b0;
  logic        i_rd              = 1'b0;
  logic [2:0]  i_cfg_dev_addr    = 3'h0;
  logic        i_cfg_dev_load    = 1'b0;
  logic [19:0] i_rf_lock_payload = 20'h0_0000;
  logic        i_rf_lock_valid   = 1'b0;
  logic        chk               = 1'b0;
  logic        chk_d             = 1'b0;
  logic [7:0]  i_mem_rdata;
  logic [7:0]  o_rdata;
  logic [15:0] o_mem_addr;
  logic [7:0]  o_mem_wdata;
  logic        o_mem_we;
  logic        o_prog_busy;
  logic [9:0]  o_lock_state;
  logic [7:0]  expq[$];
  logic [2:0]  dev;
  logic [9:0]  ls;
  logic [19:0] pl;
  logic [7:0]  b[4];
  int          bad_count         = 0;
  int          compares          = 0;
  int          cyc               = 0;
  int          we_cnt            = 0;
  logic [7:0]  we_data           = 8'h00;
  twi_if bus ();
  assign i_mem_rdata = o_mem_addr[7:0] ^ 8'ha5;
  always #5 i_clk = ~i_clk;
  lock_slave lock_slave_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(bus),
    .i_cfg_dev_addr(i_cfg_dev_addr), .i_cfg_dev_load(i_cfg_dev_load),
    .i_rf_lock_payload(i_rf_lock_payload), .i_rf_lock_valid(i_rf_lock_valid),
    .i_mem_rdata(i_mem_rdata), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_mem_we(o_mem_we), .o_prog_busy(o_prog_busy), .o_lock_state(o_lock_state));
  twi_master twi_master_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(bus),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  twi_monitor twi_monitor_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .scl_oe_n(bus.scl_oe_n), .sda_m_oe_n(bus.sda_m_oe_n), .sda_s_oe_n(bus.sda_s_oe_n),
    .scl(bus.scl), .sda(bus.sda), .o_prog_busy(o_prog_busy));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic c);
    i_addr <= a;
    i_rd   <= 1'b1;
    chk    <= c;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    chk    <= 1'b0;
    @(posedge i_clk);
  endtask
  // one byte on the wire; cmd is {start, stop, read, nack}
  task automatic op(input logic [7:0] d, input logic [3:0] c);
    wr(2'h0, d);
    wr(2'h1, {4'h0, c});
    rd(2'h1, 1'b0);
    while (o_rdata[0] === 1'b1) rd(2'h1, 1'b0);
  endtask
  task automatic tx(input logic [7:0] d, input logic [3:0] c, input logic ack);
    op(d, c);
    expq.push_back({6'h00, ack, 1'b0});
    rd(2'h1, 1'b1);
  endtask
  task automatic rx(input logic [3:0] c, input logic [7:0] e);
    op(8'h00, c);
    expq.push_back(e);
    rd(2'h2, 1'b1);
  endtask
  task automatic seek(input logic [15:0] a);
    tx({TYPE_ID, dev, 1'b0}, 4'h8, 1'b1);
    tx(a[15:8], 4'h0, 1'b1);
    tx(a[7:0], 4'h0, 1'b1);
    tx({TYPE_ID, dev, 1'b1}, 4'h8, 1'b1);
  endtask
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // result watcher, timeout and tests
  // ****************************************
  always @(posedge i_clk) begin
    chk_d <= chk & i_rd;
    if (chk_d) check(o_rdata, expq.pop_front());
  end
  always @(posedge i_clk) begin
    if (o_mem_we === 1'b1) begin
      we_cnt++;
      we_data = o_mem_wdata;
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      complete_run();
    end
  end
  initial begin
    void'($urandom(95991));
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    check(o_lock_state, 10'h000);
    tx({TYPE_ID, 3'h1, 1'b0}, 4'hc, 1'b1);
    $display("test reset done");
    for (int a = 0; a < 8; a++) begin
      dev = a[2:0];
      i_cfg_dev_addr <= dev;
      i_cfg_dev_load <= 1'b1;
      @(posedge i_clk);
      i_cfg_dev_load <= 1'b0;
      tx({TYPE_ID, dev, 1'b0}, 4'hc, 1'b1);
      tx({TYPE_ID, dev ^ 3'(1 + $urandom % 7), 1'b0}, 4'hc, 1'b0);
      tx({TYPE_ID ^ 4'h8, dev, 1'b0}, 4'hc, 1'b0);
    end
    $display("test select done");
    for (int i = 0; i < 4; i++) b[i] = 8'($urandom);
    b[0][7:4] = 4'h0;
    b[1][5:0] = 6'h00;
    b[3][5:0] = 6'h00;
    b[2][7:4] = 4'hf;
    tx({TYPE_ID, dev, 1'b0}, 4'h8, 1'b1);
    tx(8'h80, 4'h0, 1'b1);
    tx(8'h3c, 4'h0, 1'b1);
    for (int i = 0; i < 3; i++) tx(b[i], 4'h0, 1'b1);
    tx(b[3], 4'h4, 1'b1);
    tx({TYPE_ID, dev, 1'b0}, 4'hc, 1'b0);
    while (o_prog_busy === 1'b1) @(posedge i_clk);
    @(posedge i_clk);
    ls = {4'h0, b[2][3:0], b[3][7:6]};
    check(o_lock_state, ls);
    seek(LOCK_WORD_ADDR);
    rx(4'h2, b[0]);
    rx(4'h2, b[1]);
    rx(4'h2, b[2] & 8'h0f);
    rx(4'h7, b[3]);
    tx({TYPE_ID, dev, 1'b0}, 4'hc, 1'b1);
    seek(16'h2012);
    rx(4'h2, 8'h12 ^ 8'ha5);
    rx(4'h7, 8'h13 ^ 8'ha5);
    $display("test serial lock done");
    for (int k = 0; k < 3; k++) begin
      pl = 20'($urandom);
      i_rf_lock_payload <= pl;
      i_rf_lock_valid   <= 1'b1;
      @(posedge i_clk);
      i_rf_lock_valid   <= 1'b0;
      repeat (2) @(posedge i_clk);
      ls = (ls & ~pl[19:10]) | (pl[9:0] & pl[19:10]);
      check(o_lock_state, ls);
    end
    $display("test radio lock done");
    b[0] = 8'($urandom);
    tx({TYPE_ID, dev, 1'b0}, 4'h8, 1'b1);
    tx(8'h20, 4'h0, 1'b1);
    tx(8'h12, 4'h0, 1'b1);
    tx(b[0], 4'h4, 1'b1);
    while (o_prog_busy === 1'b1) @(posedge i_clk);
    @(posedge i_clk);
    check(10'(we_cnt), 10'h001);
    check({2'h0, we_data}, {2'h0, b[0]});
    $display("test memory write done");
    complete_run();
  end
endmodule
